// ==== core/cantb_pkg.sv ====
// Package of constants and carrier types for the CAN transmit buffer block.
package cantb_pkg;

   // ************************************************************
   // Register map, byte addresses on the APB.
   // ************************************************************
   localparam logic [11:0] CANTB_MCR_OFF       = 12'h000;
   localparam logic [11:0] CANTB_STAT_OFF      = 12'h004;
   localparam logic [11:0] CANTB_TEC_OFF       = 12'h008;
   localparam logic [11:0] CANTB_IRQ_STAT_OFF  = 12'h00c;
   localparam logic [11:0] CANTB_IRQ_MASK_OFF  = 12'h010;
   localparam logic [3:0]  CANTB_BUF_PAGE      = 4'h1;
   localparam logic [3:0]  CANTB_RXWIN_PAGE    = 4'h2;

   // Offsets inside one buffer page; data bytes sit at 0x20 + 4 * index.
   localparam logic [5:0]  CANTB_CTRL_OFF      = 6'h00;
   localparam logic [5:0]  CANTB_SIDH_OFF      = 6'h04;
   localparam logic [5:0]  CANTB_SIDL_OFF      = 6'h08;
   localparam logic [5:0]  CANTB_EIDH_OFF      = 6'h0c;
   localparam logic [5:0]  CANTB_EIDL_OFF      = 6'h10;
   localparam logic [5:0]  CANTB_DLC_OFF       = 6'h14;
   localparam int unsigned CANTB_DATA_BIT      = 5;

   // ************************************************************
   // Field positions, masks and reset values.
   // ************************************************************
   localparam int unsigned CANTB_REQ_BIT       = 3;
   localparam int unsigned CANTB_ABT_BIT       = 6;
   localparam int unsigned CANTB_LARB_BIT      = 5;
   localparam int unsigned CANTB_ERR_BIT       = 4;
   localparam logic [7:0]  CANTB_PRI_MASK      = 8'h03;
   localparam int unsigned CANTB_EXT_BIT       = 3;
   localparam int unsigned CANTB_RTR_BIT       = 6;
   localparam logic [7:0]  CANTB_SIDL_MASK     = 8'heb;
   localparam logic [7:0]  CANTB_DLC_MASK      = 8'h4f;
   localparam logic [3:0]  CANTB_DLC_MAX       = 4'h8;
   localparam logic [2:0]  CANTB_WIN_SEND_BUFFER_ZERO      = 3'b100;
   localparam logic [2:0]  CANTB_MODE_NORMAL   = 3'b000;
   localparam logic [2:0]  CANTB_MODE_LOOP     = 3'b010;
   localparam logic [7:0]  CANTB_MCR_RST       = 8'h80;
   localparam logic [8:0]  CANTB_TEC_RST       = 9'h000;
   localparam logic [8:0]  CANTB_TEC_ERR_STEP  = 9'h008;
   localparam logic [6:0]  CANTB_REC11_LAST    = 7'd127;
   localparam int unsigned CANTB_IRQ_W         = 4;
   localparam int unsigned CANTB_IRQ_BUSOFF    = 3;

   // ************************************************************
   // Carrier types.
   // ************************************************************
   typedef enum logic [2:0] {
      CANTB_ST_IDLE,
      CANTB_ST_HDR,
      CANTB_ST_LOAD,
      CANTB_ST_DATA,
      CANTB_ST_WAIT
   } cantb_state_t;

   typedef struct packed {
      logic        ext;
      logic [28:0] id;
      logic        rtr;
      logic [3:0]  dlc;
   } cantb_hdr_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } cantb_byte_t;

   typedef struct packed {
      logic done;
      logic fail;
      logic lost;
   } cantb_result_t;

endpackage

// ==== core/cantb_transmit_buffer.sv ====
// Three CAN transmit buffers with APB registers, arbitration, frame streaming and error counter.
//
// Behaviour
// - Identifier high byte holds standard bits 10..3 or extended bits 28..21.
// - Low byte: bits 7..5 identifier, bit 3 format flag, bits 1..0 extended 17..16.
// - Extended flag sends 29-bit identifier, otherwise 11-bit and extended bits ignored.
// - Two registers hold extended bits 15..8 and 7..0, unused for standard frames.
// - Each of three buffers has eight read-write payload byte registers.
// - Length register bit 6 becomes the frame's remote request bit.
// - Length code 0..8 selects payload bytes; codes above eight are reserved.
// - Unused identifier-low and length register bits always read zero.
// - Eight-bit read-only transmit error counter; overflow enters bus-off.
// - Counter clears after 128 runs of eleven recessive bits.
// - Writing 0x08 to buffer control requests send; request bit reads zero when sent.
// - Window field value 100 maps transmit buffer zero onto receive buffer zero addresses.
// - Request bit clears itself after a successful send.
// - Message registers ignore writes while their request bit is set.
// - Bus-off flag set when error count exceeds 255, clear otherwise.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module cantb_transmit_buffer #(
   parameter int unsigned NBUF = 3
) (
   // Clock, reset and clock enable.
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic                    ce,
   // APB slave.
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // Frame header towards the protocol engine.
   output logic                         hdr_valid,
   input  wire logic                    hdr_ready,
   output cantb_pkg::cantb_hdr_t        hdr,
   // Payload bytes towards the protocol engine.
   output logic                         byte_valid,
   input  wire logic                    byte_ready,
   output cantb_pkg::cantb_byte_t       tx_byte,
   // Outcome and bus events from the protocol engine.
   input  wire cantb_pkg::cantb_result_t result,
   input  wire logic                    rec11_seen,
   // Status and interrupt.
   output logic                         transmitter_off_flag,
   output logic                         irq
);
   import cantb_pkg::*;

   // ************************************************************
   // Storage.
   // ************************************************************
   logic [7:0]                sidh_q [NBUF];
   logic [7:0]                sidl_q [NBUF];
   logic [7:0]                eidh_q [NBUF];
   logic [7:0]                eidl_q [NBUF];
   logic [7:0]                dlc_q  [NBUF];
   logic [7:0]                data_q [NBUF][8];
   logic [NBUF-1:0]           req_q;
   logic [NBUF-1:0]           abt_q;
   logic [NBUF-1:0]           larb_q;
   logic [NBUF-1:0]           err_q;
   logic [1:0]                pri_q  [NBUF];
   logic [7:0]                mcr_q;
   logic [8:0]                tec_q;
   logic [6:0]                rec11_q;
   logic [CANTB_IRQ_W-1:0]    irq_stat_q;
   logic [CANTB_IRQ_W-1:0]    irq_mask_q;
   cantb_state_t              state_q;
   logic [1:0]                sel_q;
   logic [3:0]                idx_q;
   logic [3:0]                cnt_q;
   cantb_hdr_t                hdr_q;
   cantb_byte_t               byte_q;
   logic [31:0]               rdata_q;
   logic                      rerr_q;

   // ************************************************************
   // Helper functions.
   // ************************************************************
   function automatic logic off_ok(input logic [5:0] off);
      off_ok = off[CANTB_DATA_BIT] ? (off[1:0] == 2'b00) :
               (off == CANTB_CTRL_OFF || off == CANTB_SIDH_OFF || off == CANTB_SIDL_OFF ||
                off == CANTB_EIDH_OFF || off == CANTB_EIDL_OFF || off == CANTB_DLC_OFF);
   endfunction

   // Remote frames carry no payload; reserved codes are clamped to eight bytes.
   function automatic logic [3:0] byte_count(input logic [7:0] dlc);
      if (dlc[CANTB_RTR_BIT]) begin
         byte_count = 4'h0;
      end else if (dlc[3:0] > CANTB_DLC_MAX) begin
         byte_count = CANTB_DLC_MAX;
      end else begin
         byte_count = dlc[3:0];
      end
   endfunction

   function automatic cantb_hdr_t make_hdr(input logic [7:0] sh, input logic [7:0] sl,
                                           input logic [7:0] eh, input logic [7:0] el,
                                           input logic [7:0] dl);
      make_hdr.ext = sl[CANTB_EXT_BIT];
      if (sl[CANTB_EXT_BIT]) begin
         make_hdr.id = {sh, sl[7:5], sl[1:0], eh, el};
      end else begin
         make_hdr.id = {18'h00000, sh, sl[7:5]};
      end
      make_hdr.rtr = dl[CANTB_RTR_BIT];
      make_hdr.dlc = dl[3:0];
   endfunction

   // ************************************************************
   // Address decode.
   // ************************************************************
   logic        wr;
   logic        hit_buf;
   logic        hit_rxwin;
   logic [1:0]  bsel;
   logic [5:0]  boff;
   logic        mapped;
   logic [31:0] rd_val;
   logic        bus_off;
   logic        mode_ok;

   assign wr      = psel & penable & ce & pwrite;
   assign boff    = paddr[5:0];
   assign bus_off = tec_q[8];
   assign mode_ok = (mcr_q[7:5] == CANTB_MODE_NORMAL) || (mcr_q[7:5] == CANTB_MODE_LOOP);

   always_comb begin
      hit_buf   = 1'b0;
      hit_rxwin = 1'b0;
      bsel      = paddr[7:6];
      if (paddr[11:8] == CANTB_BUF_PAGE && 32'(paddr[7:6]) < NBUF && off_ok(boff)) begin
         hit_buf = 1'b1;
      end else if (paddr[11:8] == CANTB_RXWIN_PAGE && paddr[7:6] == 2'b00 && off_ok(boff)) begin
         hit_rxwin = 1'b1;
         bsel      = 2'b00;
         if (mcr_q[3:1] == CANTB_WIN_SEND_BUFFER_ZERO) begin
            hit_buf = 1'b1;
         end
      end
   end

   assign mapped = hit_buf | hit_rxwin | paddr == CANTB_MCR_OFF | paddr == CANTB_STAT_OFF |
                   paddr == CANTB_TEC_OFF | paddr == CANTB_IRQ_STAT_OFF | paddr == CANTB_IRQ_MASK_OFF;

   // ************************************************************
   // Read data.
   // ************************************************************
   always_comb begin
      rd_val = 32'h00000000;
      if (hit_buf) begin
         if (boff[CANTB_DATA_BIT]) begin
            rd_val[7:0] = data_q[bsel][boff[4:2]];
         end else if (boff == CANTB_CTRL_OFF) begin
            rd_val[CANTB_ABT_BIT]  = abt_q[bsel];
            rd_val[CANTB_LARB_BIT] = larb_q[bsel];
            rd_val[CANTB_ERR_BIT]  = err_q[bsel];
            rd_val[CANTB_REQ_BIT]  = req_q[bsel];
            rd_val[1:0]            = pri_q[bsel];
         end else if (boff == CANTB_SIDH_OFF) begin
            rd_val[7:0] = sidh_q[bsel];
         end else if (boff == CANTB_SIDL_OFF) begin
            rd_val[7:0] = sidl_q[bsel] & CANTB_SIDL_MASK;
         end else if (boff == CANTB_EIDH_OFF) begin
            rd_val[7:0] = eidh_q[bsel];
         end else if (boff == CANTB_EIDL_OFF) begin
            rd_val[7:0] = eidl_q[bsel];
         end else begin
            rd_val[7:0] = dlc_q[bsel] & CANTB_DLC_MASK;
         end
      end else if (paddr == CANTB_MCR_OFF) begin
         rd_val[7:0] = mcr_q;
      end else if (paddr == CANTB_STAT_OFF) begin
         rd_val[0] = bus_off;
      end else if (paddr == CANTB_TEC_OFF) begin
         rd_val[7:0] = bus_off ? 8'hff : tec_q[7:0];
      end else if (paddr == CANTB_IRQ_STAT_OFF) begin
         rd_val[CANTB_IRQ_W-1:0] = irq_stat_q;
      end else if (paddr == CANTB_IRQ_MASK_OFF) begin
         rd_val[CANTB_IRQ_W-1:0] = irq_mask_q;
      end
   end

   // Read data and error are caught in the setup cycle so that prdata comes from flip-flops.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= 32'h00000000;
         rerr_q  <= 1'b0;
      end else if (ce && psel && !penable) begin
         rdata_q <= pwrite ? 32'h00000000 : rd_val;
         rerr_q  <= ~mapped;
      end
   end

   assign pready  = psel & penable & ce;
   assign prdata  = rdata_q;
   assign pslverr = pready & rerr_q;

   // ************************************************************
   // Module control and interrupt registers.
   // ************************************************************
   logic [CANTB_IRQ_W-1:0] irq_ev;
   logic                   done_ev;
   logic                   off_ev;
   logic [8:0]             tec_err_sum;

   assign done_ev     = ce && state_q == CANTB_ST_WAIT && result.done;
   assign tec_err_sum = tec_q + CANTB_TEC_ERR_STEP;
   assign off_ev      = ce && state_q == CANTB_ST_WAIT && result.fail && !bus_off && tec_err_sum[8];

   always_comb begin
      irq_ev                  = '0;
      irq_ev[sel_q]           = done_ev;
      irq_ev[CANTB_IRQ_BUSOFF] = off_ev;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mcr_q      <= CANTB_MCR_RST;
         irq_mask_q <= '0;
         irq_stat_q <= '0;
      end else if (ce) begin
         if (wr && paddr == CANTB_MCR_OFF) begin
            mcr_q <= pwdata[7:0];
         end
         if (wr && paddr == CANTB_IRQ_MASK_OFF) begin
            irq_mask_q <= pwdata[CANTB_IRQ_W-1:0];
         end
         if (wr && paddr == CANTB_IRQ_STAT_OFF) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[CANTB_IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ************************************************************
   // Message registers, no reset.
   // ************************************************************
   always_ff @(posedge clock) begin
      if (ce && wr && hit_buf && !req_q[bsel]) begin
         if (boff[CANTB_DATA_BIT]) begin
            data_q[bsel][boff[4:2]] <= pwdata[7:0];
         end else if (boff == CANTB_SIDH_OFF) begin
            sidh_q[bsel] <= pwdata[7:0];
         end else if (boff == CANTB_SIDL_OFF) begin
            sidl_q[bsel] <= pwdata[7:0] & CANTB_SIDL_MASK;
         end else if (boff == CANTB_EIDH_OFF) begin
            eidh_q[bsel] <= pwdata[7:0];
         end else if (boff == CANTB_EIDL_OFF) begin
            eidl_q[bsel] <= pwdata[7:0];
         end else if (boff == CANTB_DLC_OFF) begin
            dlc_q[bsel] <= pwdata[7:0] & CANTB_DLC_MASK;
         end
      end
   end

   // ************************************************************
   // Buffer control registers.
   // ************************************************************
   logic ctrl_wr;
   logic busy;

   assign ctrl_wr = wr && hit_buf && boff == CANTB_CTRL_OFF;
   assign busy    = state_q != CANTB_ST_IDLE;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         req_q  <= '0;
         abt_q  <= '0;
         larb_q <= '0;
         err_q  <= '0;
         for (int b = 0; b < NBUF; b++) begin
            pri_q[b] <= 2'b00;
         end
      end else if (ce) begin
         if (ctrl_wr) begin
            pri_q[bsel] <= pwdata[1:0] & CANTB_PRI_MASK[1:0];
            if (pwdata[CANTB_REQ_BIT] && !req_q[bsel]) begin
               req_q[bsel]  <= 1'b1;
               abt_q[bsel]  <= 1'b0;
               larb_q[bsel] <= 1'b0;
               err_q[bsel]  <= 1'b0;
            end else if (!pwdata[CANTB_REQ_BIT] && req_q[bsel] && !(busy && sel_q == bsel)) begin
               req_q[bsel] <= 1'b0;
               abt_q[bsel] <= 1'b1;
            end
         end
         if (state_q == CANTB_ST_WAIT) begin
            if (result.done) begin
               req_q[sel_q] <= 1'b0;
            end
            if (result.fail) begin
               err_q[sel_q] <= 1'b1;
            end
            if (result.lost) begin
               larb_q[sel_q] <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // Arbitration and frame streaming.
   // ************************************************************
   logic       pick_any;
   logic [1:0] pick;

   // Highest priority wins; on a tie the higher buffer number wins.
   always_comb begin
      pick_any = 1'b0;
      pick     = 2'b00;
      for (int b = 0; b < NBUF; b++) begin
         if (req_q[b] && (!pick_any || pri_q[b] >= pri_q[pick])) begin
            pick_any = 1'b1;
            pick     = 2'(b);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= CANTB_ST_IDLE;
         sel_q   <= 2'b00;
         idx_q   <= 4'h0;
         cnt_q   <= 4'h0;
         hdr_q   <= '0;
         byte_q  <= '0;
      end else if (ce) begin
         case (state_q)
            CANTB_ST_IDLE: begin
               if (pick_any && mode_ok && !bus_off) begin
                  sel_q   <= pick;
                  hdr_q   <= make_hdr(sidh_q[pick], sidl_q[pick], eidh_q[pick], eidl_q[pick], dlc_q[pick]);
                  cnt_q   <= byte_count(dlc_q[pick]);
                  idx_q   <= 4'h0;
                  state_q <= CANTB_ST_HDR;
               end
            end
            CANTB_ST_HDR: begin
               if (hdr_ready) begin
                  state_q <= (cnt_q == 4'h0) ? CANTB_ST_WAIT : CANTB_ST_LOAD;
               end
            end
            CANTB_ST_LOAD: begin
               byte_q.data <= data_q[sel_q][idx_q[2:0]];
               byte_q.last <= (idx_q + 4'h1) == cnt_q;
               state_q     <= CANTB_ST_DATA;
            end
            CANTB_ST_DATA: begin
               if (byte_ready) begin
                  idx_q   <= idx_q + 4'h1;
                  state_q <= byte_q.last ? CANTB_ST_WAIT : CANTB_ST_LOAD;
               end
            end
            CANTB_ST_WAIT: begin
               if (result.done || result.fail || result.lost) begin
                  state_q <= CANTB_ST_IDLE;
               end
            end
            default: begin
               state_q <= CANTB_ST_IDLE;
            end
         endcase
      end
   end

   assign hdr_valid  = state_q == CANTB_ST_HDR;
   assign hdr        = hdr_q;
   assign byte_valid = state_q == CANTB_ST_DATA;
   assign tx_byte    = byte_q;

   // ************************************************************
   // Transmit error counter and bus-off recovery.
   // ************************************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tec_q   <= CANTB_TEC_RST;
         rec11_q <= 7'd0;
      end else if (ce) begin
         if (bus_off) begin
            if (rec11_seen) begin
               if (rec11_q == CANTB_REC11_LAST) begin
                  tec_q   <= CANTB_TEC_RST;
                  rec11_q <= 7'd0;
               end else begin
                  rec11_q <= rec11_q + 7'd1;
               end
            end
         end else if (state_q == CANTB_ST_WAIT && result.fail) begin
            tec_q <= tec_err_sum;
         end else if (done_ev && tec_q != CANTB_TEC_RST) begin
            tec_q <= tec_q - 9'd1;
         end
      end
   end

   assign transmitter_off_flag = bus_off;

endmodule // cantb_transmit_buffer

// ==== verif/cantb_monitor.sv ====
// Port checker of the CAN transmit buffer, bound to the design.
module cantb_monitor
   import cantb_pkg::*;
(
   // Watched ports.
   input wire logic                     clock,
   input wire logic                     sys_rst,
   input wire logic                     ce,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic                     hdr_valid,
   input wire logic                     hdr_ready,
   input wire cantb_pkg::cantb_hdr_t    hdr,
   input wire logic                     byte_valid,
   input wire logic                     byte_ready,
   input wire cantb_pkg::cantb_byte_t   tx_byte,
   input wire cantb_pkg::cantb_result_t result,
   input wire logic                     rec11_seen,
   input wire logic                     transmitter_off_flag,
   input wire logic                     irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] n_q;
   logic [3:0] cnt_q;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clock) begin
      if (hdr_valid && hdr_ready) begin
         n_q <= hdr.rtr ? 4'h0 : ((hdr.dlc > CANTB_DLC_MAX) ? CANTB_DLC_MAX : hdr.dlc);
         cnt_q <= 4'h0;
      end else if (byte_valid && byte_ready) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   sequence hdr_take;
      hdr_valid && hdr_ready;
   endsequence
   sequence byte_take;
      byte_valid && byte_ready;
   endsequence
   apb_ready_a: assert property (pready == (psel && penable && ce)) else $error("pready wrong");
   err_access_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
   hdr_hold_a: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr)) else $error("header moved");
   byte_hold_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(tx_byte)) else $error("byte moved");
   byte_gap_a: assert property (byte_take |=> !byte_valid) else $error("no load cycle");
   first_byte_a: assert property (hdr_take ##0 (!hdr.rtr && hdr.dlc != 4'h0) |=> !byte_valid ##1 byte_valid) else $error("first byte late");
   no_payload_a: assert property (hdr_take ##0 (hdr.rtr || hdr.dlc == 4'h0) |=> !byte_valid [*2]) else $error("payload sent");
   byte_count_a: assert property (byte_valid |-> cnt_q < n_q && tx_byte.last == (cnt_q == n_q - 4'h1)) else $error("byte count");
   off_cause_a: assert property ($rose(transmitter_off_flag) |-> $past(result.fail)) else $error("off without fail");
   off_clear_a: assert property ($fell(transmitter_off_flag) |-> $past(rec11_seen)) else $error("off cleared early");
   reset_idle_a: assert property ($fell(sys_rst) |-> !hdr_valid && !byte_valid && !irq && !transmitter_off_flag) else $error("reset");
endmodule // cantb_monitor

bind cantb_transmit_buffer cantb_monitor mon (.*);

// ==== verif/cantb_engine_model.sv ====
// Protocol engine model that takes frames with random stalls and reports the outcome.
module cantb_engine_model
   import cantb_pkg::*;
(
   // Clock, reset and outcome choice.
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic                   fail_on,
   // Frame stream.
   input  wire logic                   hdr_valid,
   input  wire cantb_pkg::cantb_hdr_t  hdr,
   input  wire logic                   byte_valid,
   input  wire cantb_pkg::cantb_byte_t tx_byte,
   output logic                        hdr_ready,
   output logic                        byte_ready,
   output cantb_pkg::cantb_result_t    result,
   // What was received.
   output cantb_pkg::cantb_hdr_t       got_hdr,
   output logic [3:0]                  got_n,
   output logic [63:0]                 got_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] lf_q;
   logic [3:0]  wait_q;
   always_ff @(posedge clock) begin
      result <= '0;
      if (sys_rst) begin
         lf_q <= 16'hace1;
         hdr_ready <= 1'b0;
         byte_ready <= 1'b0;
         got_n <= 4'h0;
         wait_q <= 4'h0;
      end else begin
         lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
         hdr_ready <= lf_q[0];
         byte_ready <= lf_q[3] | lf_q[7];
         if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
            result.done <= (wait_q == 4'h1) && !fail_on;
            result.fail <= (wait_q == 4'h1) && fail_on;
         end
         if (hdr_valid && hdr_ready) begin
            got_hdr <= hdr;
            got_n <= 4'h0;
            wait_q <= (hdr.rtr || hdr.dlc == 4'h0) ? 4'h8 : 4'h0;
         end
         if (byte_valid && byte_ready) begin
            got_data[got_n * 8 +: 8] <= tx_byte.data;
            got_n <= got_n + 4'h1;
            if (tx_byte.last) wait_q <= 4'h8;
         end
      end
   end
endmodule // cantb_engine_model

// ==== verif/cantb_transmit_buffer_bench.sv ====
// Self-checking bench of the CAN transmit buffer block.
module cantb_transmit_buffer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cantb_pkg::*;
   logic          clock = 1'b0;
   logic          sys_rst = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic          rec11_seen = 1'b0, fail_on = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0;
   logic [31:0]   seed = 32'h20b5b335;
   logic [31:0]   prdata, rd;
   logic          pready, pslverr, err, hdr_valid, hdr_ready, byte_valid, byte_ready, transmitter_off_flag, irq;
   cantb_hdr_t    hdr, got_hdr;
   cantb_byte_t   tx_byte;
   cantb_result_t result;
   logic [3:0]    got_n;
   logic [63:0]   got_data, dat;
   logic [7:0]    sh, sl, eh, el, dl;
   int            n_fail = 0;
   int            samples_checked = 0;
   initial forever #20 clock = ~clock;
   cantb_transmit_buffer dut (.*, .ce(1'b1));
   cantb_engine_model eng (.*);
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [3:0] nbytes(input logic [7:0] d);
      return d[6] ? 4'h0 : ((d[3:0] > 4'h8) ? 4'h8 : d[3:0]);
   endfunction
   task results();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_fail++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task frame(input int it);
      logic [11:0] base, rbase;
      logic [1:0]  b;
      int          k;
      b = (it == 0) ? 2'd1 : 2'(xs() % 3);
      rbase = 12'h100 + {4'h0, b, 6'h00};
      base = (b == 2'd0) ? 12'h200 : rbase;
      if (it > 0) apb(1'b1, CANTB_MCR_OFF, it[1] ? 8'h48 : 8'h08);
      {sh, sl, eh, el} = xs();
      dl = 8'(xs());
      dat = {xs(), xs()};
      apb(1'b1, CANTB_IRQ_MASK_OFF, {7'h0, it[0]} << b);
      apb(1'b1, base + 12'h04, sh);
      apb(1'b1, base + 12'h08, sl);
      apb(1'b1, base + 12'h0c, eh);
      apb(1'b1, base + 12'h10, el);
      apb(1'b1, base + 12'h14, dl);
      for (k = 0; k < 8; k++) apb(1'b1, base + 12'h20 + 12'(4 * k), dat[8 * k +: 8]);
      apb(1'b1, base, 8'h08);
      apb(1'b1, base + 12'h04, ~sh);
      if (it == 0) begin
         repeat (20) @(posedge clock);
         chk(hdr_valid, 1'b0);
         apb(1'b1, CANTB_MCR_OFF, 8'h00);
      end
      for (k = 0; k < 300; k++) begin
         apb(1'b0, base, 8'h00);
         if (rd[3] === 1'b0) break;
      end
      if (k == 300) begin
         n_fail++;
         results();
      end
      chk(got_hdr.ext, sl[3]);
      chk(sl[3] ? got_hdr.id : got_hdr.id[10:0], sl[3] ? {sh, sl[7:5], sl[1:0], eh, el} : {sh, sl[7:5]});
      chk({got_hdr.rtr, got_hdr.dlc}, {dl[6], dl[3:0]});
      chk(got_n, nbytes(dl));
      for (k = 0; k < 8; k++) if (4'(k) < nbytes(dl)) chk(got_data[8 * k +: 8], dat[8 * k +: 8]);
      chk(irq, it[0]);
      apb(1'b0, CANTB_IRQ_STAT_OFF, 8'h00);
      chk(rd[b], 1'b1);
      apb(1'b1, CANTB_IRQ_STAT_OFF, 8'h01 << b);
      apb(1'b0, rbase + 12'h04, 8'h00);
      chk(irq, 1'b0);
      chk(rd, {24'h0, sh});
      apb(1'b0, rbase + 12'h08, 8'h00);
      chk(rd, {24'h0, sl & CANTB_SIDL_MASK});
      apb(1'b0, rbase + 12'h14, 8'h00);
      chk(rd, {24'h0, dl & CANTB_DLC_MASK});
   endtask
   initial begin
      int k;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      apb(1'b0, CANTB_TEC_OFF, 8'h00);
      chk(rd, 32'h0);
      apb(1'b1, CANTB_TEC_OFF, 8'hff);
      apb(1'b0, CANTB_TEC_OFF, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, 12'hffc, 8'h00);
      chk({err, rd}, {1'b1, 32'h0});
      for (k = 0; k < 14; k++) frame(k);
      fail_on <= 1'b1;
      apb(1'b1, 12'h114, 8'h40);
      apb(1'b1, 12'h100, 8'h08);
      for (k = 0; k < 5000 && transmitter_off_flag !== 1'b1; k++) @(posedge clock);
      chk(transmitter_off_flag, 1'b1);
      apb(1'b0, CANTB_TEC_OFF, 8'h00);
      chk(rd, 32'hff);
      apb(1'b0, CANTB_IRQ_STAT_OFF, 8'h00);
      chk(rd[CANTB_IRQ_BUSOFF], 1'b1);
      fail_on <= 1'b0;
      for (k = 0; k < 128; k++) begin
         if (k == 127) chk(transmitter_off_flag, 1'b1);
         @(posedge clock);
         rec11_seen <= 1'b1;
         @(posedge clock);
         rec11_seen <= 1'b0;
      end
      repeat (2) @(posedge clock);
      chk(transmitter_off_flag, 1'b0);
      apb(1'b0, CANTB_TEC_OFF, 8'h00);
      chk(rd, 32'h0);
      results();
   end
endmodule // cantb_transmit_buffer_bench
